// >>> design/pmst_map.vh
// Purpose: offsets, field positions, resets and timing for the pm block
// Assumes: byte-addressed i/o window relative to pm_io_base
// Notes: included by the pm sleep control and timer files
`ifndef PMST_MAP_VH
`define PMST_MAP_VH

`define PMST_OFF_SLEEP_CTRL 8'h04
`define PMST_OFF_TIMER 8'h08
`define PMST_OFF_EVT 8'h0c

`define PMST_BIT_SLEEP_TRIG 13
`define PMST_BIT_KIND_HI 12
`define PMST_BIT_KIND_LO 10
`define PMST_BIT_GLOBAL_REL 2
`define PMST_BIT_ROUTE 0
`define PMST_BIT_WRAP 22

`define PMST_EVT_BIT_FLAG 0
`define PMST_EVT_BIT_EN 1

`define PMST_RST_SLEEP_CTRL 32'h0000_0000
`define PMST_RST_TIMER 24'h00_0000

`define PMST_KIND_ON 3'h0
`define PMST_KIND_STOPGRANT 3'h1
`define PMST_KIND_MEM 3'h5
`define PMST_KIND_DISK 3'h6
`define PMST_KIND_OFF 3'h7

// reference is divided down to the tick rate
`define PMST_REF_DIV 4
`define PMST_REF_DIV_W 2

`endif

// >>> design/pmst_timer.v
// Purpose: 24-bit counter, held while run is low, with bit-22 fall detect
// Assumes: tick_ref is a synchronised level of the reference clock
// Notes: counts one per four reference rising edges
`timescale 1ns/1ps
`include "pmst_map.vh"
module pmst_timer #(
  parameter WIDTH = 24
) (
  input wire sys_clk,
  input wire nrst,
  input wire run,
  input wire tick_ref,
  output reg [WIDTH-1:0] count_q,
  output reg wrap_pulse_q
);
  reg ref_prev_q;
  reg [`PMST_REF_DIV_W-1:0] div_q;
  wire ref_rise;
  wire adv;
  wire [WIDTH-1:0] count_d;

  assign ref_rise = tick_ref & ~ref_prev_q;
  assign adv = run & ref_rise & (div_q == {`PMST_REF_DIV_W{1'b1}});
  // all-ones rolls to zero without a pause
  assign count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_prev_q <= 1'b0;
      div_q <= {`PMST_REF_DIV_W{1'b0}};
      count_q <= `PMST_RST_TIMER;
      wrap_pulse_q <= 1'b0;
    end else begin
      ref_prev_q <= tick_ref;
      if (run && ref_rise)
        div_q <= div_q + {{(`PMST_REF_DIV_W-1){1'b0}}, 1'b1};
      wrap_pulse_q <= 1'b0;
      if (adv) begin
        count_q <= count_d;
        // fall of bit 22 every 2^23 ticks, about 2.3435 s
        wrap_pulse_q <= count_q[`PMST_BIT_WRAP] & ~count_d[`PMST_BIT_WRAP];
      end
    end
  end
endmodule // pmst_timer

// >>> design/pmst_sleep_ctrl.v
// Operation
// - sleep trigger bit 13 is write-only and reads zero.
// - writing one to the trigger starts the selected sleep sequence.
// - three-bit read/write sleep kind field at bits 12 to 10.
// - kind 000 is on; 001 asserts stop-clock and processor doze.
// - kind 101 asserts the suspend-to-memory rail control.
// - kind 110 asserts suspend-to-memory and soft-off rail controls.
// - kind 111 asserts suspend-to-memory and soft-off rail controls.
// - writing one to global release bit 2 raises a firmware event.
// - global release always reads zero.
// - routing select bit 0 steers events to sci (1) or smi (0).
// - routed events include power status bits 10, 8, 0 and general events.
// - timer register returns 24-bit running count, read only.
// - counter advances at reference divided by four.
// - counter clears on reset, then counts while working.
// - each fall of counter bit 22 sets the timer wrap flag.
// - that fall recurs every 2.3435 seconds while counting.
// - wrap enable set means the wrap flag raises an interrupt.
// - writes to the timer register are ignored.
// - enabled wrap signals sci or smi per routing select.
//
// Purpose: power management sleep control register and pm timer
// Assumes: simple synchronous i/o port: one-cycle rd/wr strobes, byte addr
// Notes: other power and general event status arrive as ready-made levels
`timescale 1ns/1ps
`include "pmst_map.vh"
module pmst_sleep_ctrl (
  input wire sys_clk,
  input wire nrst,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_addr,
  input wire [31:0] io_wdata,
  output reg [31:0] io_rdata_q,
  input wire ref_clk_14m,
  input wire power_event_pending,
  input wire general_event_pending,
  output reg processor_stop_clock_n_q,
  output reg processor_doze_n_q,
  output reg suspend_memory_rail_n_q,
  output reg soft_off_rail_n_q,
  output reg sci_q,
  output reg system_mgmt_irq_n_q,
  output reg firmware_event_q
);
  reg ref_s1_q;
  reg ref_s2_q;
  reg [2:0] sleep_kind_q;
  reg routing_select_q;
  reg timer_wrap_flag_q;
  reg timer_wrap_enable_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [2:0] active_kind_q;
  wire [23:0] timer_count;
  wire wrap_pulse;
  wire wr_ctrl;
  wire wr_evt;
  wire trig;
  wire kind_ok;
  wire evt_req;
  wire run;

  localparam [1:0] ST_WORK = 2'h0;
  localparam [1:0] ST_ENTER = 2'h1;
  localparam [1:0] ST_SLEEP = 2'h2;
  // named as a 32-bit parameter so the kind field can be cut out of the reset word
  localparam [31:0] CTRL_RST = `PMST_RST_SLEEP_CTRL;

  // reference pin is asynchronous to sys_clk
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
    end else begin
      ref_s1_q <= ref_clk_14m;
      ref_s2_q <= ref_s1_q;
    end
  end

  assign run = (state_q == ST_WORK);

  pmst_timer #(
    .WIDTH(24)
  ) u_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(run),
    .tick_ref(ref_s2_q),
    .count_q(timer_count),
    .wrap_pulse_q(wrap_pulse)
  );

  assign wr_ctrl = io_wr && (io_addr == `PMST_OFF_SLEEP_CTRL);
  assign wr_evt = io_wr && (io_addr == `PMST_OFF_EVT);
  assign trig = wr_ctrl && io_wdata[`PMST_BIT_SLEEP_TRIG];
  // reserved kinds never leave the working state
  assign kind_ok =
    (io_wdata[`PMST_BIT_KIND_HI:`PMST_BIT_KIND_LO] == `PMST_KIND_STOPGRANT) ||
    (io_wdata[`PMST_BIT_KIND_HI:`PMST_BIT_KIND_LO] == `PMST_KIND_MEM) ||
    (io_wdata[`PMST_BIT_KIND_HI:`PMST_BIT_KIND_LO] == `PMST_KIND_DISK) ||
    (io_wdata[`PMST_BIT_KIND_HI:`PMST_BIT_KIND_LO] == `PMST_KIND_OFF);

  // registers and wrap flag
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sleep_kind_q <= CTRL_RST[`PMST_BIT_KIND_HI:`PMST_BIT_KIND_LO];
      routing_select_q <= 1'b0;
      timer_wrap_flag_q <= 1'b0;
      timer_wrap_enable_q <= 1'b0;
      firmware_event_q <= 1'b0;
    end else begin
      firmware_event_q <= wr_ctrl && io_wdata[`PMST_BIT_GLOBAL_REL];
      if (wr_ctrl) begin
        sleep_kind_q <= io_wdata[`PMST_BIT_KIND_HI:`PMST_BIT_KIND_LO];
        routing_select_q <= io_wdata[`PMST_BIT_ROUTE];
      end
      if (wr_evt)
        timer_wrap_enable_q <= io_wdata[`PMST_EVT_BIT_EN];
      // set beats a same-cycle write-one clear
      if (wrap_pulse)
        timer_wrap_flag_q <= 1'b1;
      else if (wr_evt && io_wdata[`PMST_EVT_BIT_FLAG])
        timer_wrap_flag_q <= 1'b0;
    end
  end

  // read mux; timer writes fall through with no effect
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      io_rdata_q <= 32'h0000_0000;
    end else if (io_rd) begin
      case (io_addr)
        `PMST_OFF_SLEEP_CTRL: begin
          // trigger and global release read zero
          io_rdata_q <= {18'h0_0000, 1'b0, sleep_kind_q, 7'h00,
                         1'b0, 1'b0, routing_select_q};
        end
        `PMST_OFF_TIMER: io_rdata_q <= {8'h00, timer_count};
        `PMST_OFF_EVT: begin
          io_rdata_q <= {30'h0000_0000, timer_wrap_enable_q,
                         timer_wrap_flag_q};
        end
        default: io_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      io_rdata_q <= 32'h0000_0000;
    end
  end

  // sleep sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_WORK: begin
        if (trig && kind_ok)
          state_d = ST_ENTER;
      end
      ST_ENTER: state_d = ST_SLEEP;
      ST_SLEEP: begin
        // wake handling lives elsewhere; a new trigger with kind on wakes
        if (trig &&
            io_wdata[`PMST_BIT_KIND_HI:`PMST_BIT_KIND_LO] == `PMST_KIND_ON)
          state_d = ST_WORK;
      end
      default: state_d = ST_WORK;
    endcase
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_WORK;
      active_kind_q <= `PMST_KIND_ON;
      processor_stop_clock_n_q <= 1'b1;
      processor_doze_n_q <= 1'b1;
      suspend_memory_rail_n_q <= 1'b1;
      soft_off_rail_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      if (state_q == ST_WORK && state_d == ST_ENTER)
        active_kind_q <= io_wdata[`PMST_BIT_KIND_HI:`PMST_BIT_KIND_LO];
      if (state_d == ST_WORK) begin
        processor_stop_clock_n_q <= 1'b1;
        processor_doze_n_q <= 1'b1;
        suspend_memory_rail_n_q <= 1'b1;
        soft_off_rail_n_q <= 1'b1;
      end else if (state_q == ST_ENTER) begin
        // processor is stopped in every kind, rails change in the same cycle
        processor_stop_clock_n_q <= 1'b0;
        processor_doze_n_q <= 1'b0;
        suspend_memory_rail_n_q <=
          !(active_kind_q == `PMST_KIND_MEM ||
            active_kind_q == `PMST_KIND_DISK ||
            active_kind_q == `PMST_KIND_OFF);
        soft_off_rail_n_q <=
          !(active_kind_q == `PMST_KIND_DISK ||
            active_kind_q == `PMST_KIND_OFF);
      end
    end
  end

  // routing of wrap and other covered events
  assign evt_req = (timer_wrap_flag_q && timer_wrap_enable_q) ||
                   power_event_pending || general_event_pending;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sci_q <= 1'b0;
      system_mgmt_irq_n_q <= 1'b1;
    end else begin
      sci_q <= evt_req && routing_select_q;
      system_mgmt_irq_n_q <= !(evt_req && !routing_select_q);
    end
  end
endmodule // pmst_sleep_ctrl

// >>> sim/pmst_ref_osc.sv
// Purpose: reference oscillator at the timer's far side
// Assumes: free-running, phase unrelated to sys_clk
// Notes: half period rounded to 1 ps
`timescale 1ns/1ps
module pmst_ref_osc (
  output logic ref_clk_14m
);
  initial begin
    ref_clk_14m = 1'b0;
    #3.3;
    forever #34.921 ref_clk_14m = ~ref_clk_14m;
  end
endmodule // pmst_ref_osc

// >>> sim/pmst_chk.sv
// Purpose: port checks for the sleep control block
// Assumes: sees only top-level ports
// Notes: bound from the bench top file
`timescale 1ns/1ps
module pmst_chk (
  input wire sys_clk,
  input wire nrst,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_addr,
  input wire [31:0] io_wdata,
  input wire [31:0] io_rdata_q,
  input wire power_event_pending,
  input wire processor_stop_clock_n_q,
  input wire processor_doze_n_q,
  input wire suspend_memory_rail_n_q,
  input wire soft_off_rail_n_q,
  input wire sci_q,
  input wire system_mgmt_irq_n_q,
  input wire firmware_event_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire cw = io_wr && io_addr == 8'h04;
  rd_zero_bits_a: assert property (
    io_rd |=> !io_rdata_q[13] && !io_rdata_q[2])
    else $error("write-only bit read back");
  fw_pulse_a: assert property (
    cw && io_wdata[2] |=> firmware_event_q)
    else $error("no firmware event");
  fw_cause_a: assert property (
    !(cw && io_wdata[2]) |=> !firmware_event_q)
    else $error("stray firmware event");
  mem_rail_a: assert property (
    cw && io_wdata[13:10] == 4'hd |=> ##1
    !suspend_memory_rail_n_q && soft_off_rail_n_q)
    else $error("memory sleep rails wrong");
  off_rail_a: assert property (
    cw && io_wdata[13:11] == 3'h7 |=> ##1
    !suspend_memory_rail_n_q && !soft_off_rail_n_q)
    else $error("off rails wrong");
  stop_grant_a: assert property (
    cw && io_wdata[13:10] == 4'h9 |=> ##1
    !processor_stop_clock_n_q && !processor_doze_n_q &&
    suspend_memory_rail_n_q)
    else $error("stop grant outputs wrong");
  reserved_kind_a: assert property (
    cw && io_wdata[13] && io_wdata[12:10] inside {3'h2, 3'h3, 3'h4} &&
    processor_stop_clock_n_q |=> ##1
    processor_stop_clock_n_q && suspend_memory_rail_n_q)
    else $error("reserved kind slept");
  sleep_hold_a: assert property (
    !suspend_memory_rail_n_q && !cw |=> !suspend_memory_rail_n_q)
    else $error("sleep dropped");
  route_excl_a: assert property (
    !(sci_q && !system_mgmt_irq_n_q))
    else $error("both interrupts raised");
  pend_route_a: assert property (
    power_event_pending |=> sci_q || !system_mgmt_irq_n_q)
    else $error("pending event not routed");
  cover property (firmware_event_q);
  cover property (!soft_off_rail_n_q);
  cover property (sci_q);
endmodule // pmst_chk

// >>> sim/tb_pmst_sleep_ctrl.sv
// Purpose: directed bench for the sleep control block
// Assumes: one-cycle strobes, read data the cycle after
// Notes: timer wrap needs seconds of run, checked by neither bench nor checker
`timescale 1ns/1ps
module tb_pmst_sleep_ctrl;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [31:0] io_wdata = 32'h0000_0000;
  logic pend_p = 1'b0;
  logic pend_g = 1'b0;
  logic fw_seen;
  logic [31:0] t0, t1;
  wire [31:0] rdat;
  wire refc, stp, doz, mem, off, sci, smi, fw;
  int n_mismatch = 0;
  int total_checks = 0;
  pmst_ref_osc i_pmst_ref_osc (.ref_clk_14m(refc));
  pmst_sleep_ctrl i_pmst_sleep_ctrl (.sys_clk(sys_clk), .nrst(nrst),
    .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata_q(rdat), .ref_clk_14m(refc), .power_event_pending(pend_p),
    .general_event_pending(pend_g), .processor_stop_clock_n_q(stp),
    .processor_doze_n_q(doz), .suspend_memory_rail_n_q(mem),
    .soft_off_rail_n_q(off), .sci_q(sci), .system_mgmt_irq_n_q(smi),
    .firmware_event_q(fw));
  always #5 sys_clk = ~sys_clk;
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
    fw_seen = fw;
    cyc(1);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    d = rdat;
    cyc(1);
  endtask
  task t_reset;
    chk({25'h0, stp, doz, mem, off, sci, smi, fw}, 32'h7a);
    rd(8'h04, t0);
    chk(t0, 32'h0000_0000);
    rd(8'h10, t0);
    chk(t0, 32'h0000_0000);
    $display("t_reset done");
  endtask
  task t_ctrl;
    wr(8'h04, 32'h0000_1400);
    chk({31'h0, fw_seen}, 32'h0);
    rd(8'h04, t0);
    chk(t0, 32'h0000_1400);
    wr(8'h04, 32'h0000_3405);
    chk({31'h0, fw_seen}, 32'h1);
    rd(8'h04, t0);
    chk(t0, 32'h0000_1401);
    wr(8'h04, 32'h0000_2000);
    $display("t_ctrl done");
  endtask
  task t_sleep;
    logic [2:0] k;
    logic [3:0] e;
    for (int i = 1; i < 8; i++) begin
      k = i[2:0];
      e = (k == 3'h1) ? 4'h3 : (k == 3'h5) ? 4'h1 : (k > 3'h5) ? 4'h0 : 4'hf;
      wr(8'h04, {18'h0, 1'b1, k, 10'h0});
      cyc(2);
      chk({28'h0, stp, doz, mem, off}, {28'h0, e});
      wr(8'h04, 32'h0000_2000);
      cyc(2);
      chk({28'h0, stp, doz, mem, off}, 32'hf);
    end
    $display("t_sleep done");
  endtask
  task t_timer;
    rd(8'h08, t0);
    cyc(200);
    rd(8'h08, t1);
    chk({31'h0, t1 - t0 >= 6 && t1 - t0 <= 8}, 32'h1);
    chk({24'h0, t1[31:24]}, 32'h0);
    wr(8'h08, 32'h00ff_ffff);
    rd(8'h08, t0);
    chk({31'h0, t0 >= t1 && t0 - t1 < 3}, 32'h1);
    $display("t_timer done");
  endtask
  task t_route;
    wr(8'h04, 32'h0000_0001);
    pend_p = 1'b1;
    cyc(2);
    chk({30'h0, sci, smi}, 32'h3);
    pend_p = 1'b0;
    pend_g = 1'b1;
    wr(8'h04, 32'h0000_0000);
    cyc(1);
    chk({30'h0, sci, smi}, 32'h0);
    pend_g = 1'b0;
    cyc(2);
    chk({30'h0, sci, smi}, 32'h1);
    $display("t_route done");
  endtask
  task t_evt;
    wr(8'h0c, 32'h0000_0003);
    rd(8'h0c, t0);
    chk(t0, 32'h0000_0002);
    chk({30'h0, sci, smi}, 32'h1);
    wr(8'h0c, 32'h0000_0000);
    rd(8'h0c, t0);
    chk(t0, 32'h0000_0000);
    $display("t_evt done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    cyc(16);
    nrst = 1'b1;
    cyc(1);
    t_reset;
    t_ctrl;
    t_sleep;
    t_timer;
    t_route;
    t_evt;
    print_verdict;
  end
  // tests need about 3.1 us; allow about sixteen times that
  initial begin
    #50000;
    n_mismatch++;
    print_verdict;
  end
endmodule // tb_pmst_sleep_ctrl
bind pmst_sleep_ctrl pmst_chk i_pmst_chk (.sys_clk, .nrst, .io_wr, .io_rd,
  .io_addr, .io_wdata, .io_rdata_q, .power_event_pending,
  .processor_stop_clock_n_q, .processor_doze_n_q, .suspend_memory_rail_n_q,
  .soft_off_rail_n_q, .sci_q, .system_mgmt_irq_n_q, .firmware_event_q);
